//--- shared/dword_sync_pkg.sv
package dword_sync_pkg;

    // ----------------------------------------
    // Character and dword encodings
    // ----------------------------------------
    localparam logic [7:0] K28_5_BYTE = 8'hBC;
    localparam logic [7:0] K28_3_BYTE = 8'h7C;
    localparam int DWORD_BYTES = 4;
    localparam int PRIM_NEEDED = 3;
    localparam int INVALID_LIMIT = 4;
    localparam logic [1:0] PRIM_CNT_W0 = 2'h0;

    // ----------------------------------------
    // Replacement primitives for relayed invalid dwords
    // ----------------------------------------
    localparam logic [31:0] ERROR_PRIM_DEFAULT = 32'h000000BC;
    localparam logic [31:0] SATA_ERROR_PRIM_DEFAULT = 32'h0000007C;

    // ----------------------------------------
    // One received dword, byte 0 is the first transmitted
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] byte3;
        logic [7:0] byte2;
        logic [7:0] byte1;
        logic [7:0] byte0;
        logic [3:0] is_k;
        logic code_err;
    } rx_dword_t;

    typedef enum logic [9:0] {
        ACQ_START = 10'h001,
        ACQ_ONE = 10'h002,
        ACQ_TWO = 10'h004,
        SYNC_ACQ = 10'h008,
        LOSE_ONE = 10'h010,
        LOSE_ONE_V = 10'h020,
        LOSE_TWO = 10'h040,
        LOSE_TWO_V = 10'h080,
        LOSE_THREE = 10'h100,
        LOSE_THREE_V = 10'h200
    } sync_state_t;

endpackage

//--- core/dword_sync_machine.sv
// Operation
// - Invalid dword in sync goes to lose-one
// - Relayed invalid dword replaced by error primitive
// - Valid dword keeps sync state
// - Loss of signal restarts acquisition
// - Lose-one valid goes to lose-one-valid
// - Lose-one invalid goes to lose-two
// - Lose-one-valid valid returns to sync
// - Lose-one-valid invalid goes to lose-two
// - Lose-two valid goes to lose-two-valid
// - Lose-two invalid goes to lose-three
// - Lose-two-valid valid steps to lose-one
// - Lose-two-valid invalid goes to lose-three
// - Lose-three valid goes to lose-three-valid
// - Lose-three invalid restarts acquisition, sync lost
// - Lose-three-valid valid steps to lose-two
// - Lose-three-valid invalid restarts acquisition
// - Primitive is K28.5/K28.3 plus three data
// - Bytes handled by position only
// - Acquisition realigns K28.5 into first byte
// - Sync after three valid primitives enables downstream
// - Data withheld while not synchronized
`timescale 1ns/1ps
module dword_sync_machine
    import dword_sync_pkg::*;
#(
    parameter logic [31:0] ERROR_PRIM = ERROR_PRIM_DEFAULT,
    parameter logic [31:0] SATA_ERROR_PRIM = SATA_ERROR_PRIM_DEFAULT
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_is_k,
    input wire logic rx_byte_err,
    input wire logic rx_byte_valid,
    input wire logic loss_of_signal,
    input wire logic sata_mode,
    output logic sync_valid,
    output logic conn_enable,
    output dword_sync_pkg::rx_dword_t out_dword,
    output logic out_valid,
    output logic out_invalid,
    output logic [31:0] relay_dword,
    output logic relay_valid,
    output logic sync_lost
);
    import dword_sync_pkg::*;

    // ----------------------------------------
    // Loss-of-signal synchroniser
    // ----------------------------------------
    logic los_s1_r;
    logic los_s2_r;
    logic los_s3_r;
    logic los_r;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            los_s1_r <= 1'b1;
            los_s2_r <= 1'b1;
            los_s3_r <= 1'b1;
        end
        else
        begin
            // Three-stage capture of the pin
            los_s1_r <= loss_of_signal;
            los_s2_r <= los_s1_r;
            los_s3_r <= los_s2_r;
        end
    end

    // Change accepted once last two stages agree
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            los_r <= 1'b1;
        end
        else if (los_s2_r == los_s3_r)
        begin
            los_r <= los_s3_r;
        end
    end

    // ----------------------------------------
    // Byte assembly into dwords
    // ----------------------------------------
    sync_state_t state_r;
    sync_state_t state_nxt;
    logic [1:0] pos_r;
    rx_dword_t asm_r;
    rx_dword_t dw_r;
    logic dw_stb_r;
    logic acquiring;
    logic comma;
    logic realign;
    logic first_pos;
    logic last_pos;

    assign acquiring = (state_r == ACQ_START);
    assign comma = rx_byte_is_k && !rx_byte_err && (rx_byte == K28_5_BYTE);
    assign realign = rx_byte_valid && acquiring && comma;
    assign first_pos = realign || (pos_r == PRIM_CNT_W0);
    assign last_pos = rx_byte_valid && !first_pos && (pos_r == 2'h3);

    // Byte position counter
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pos_r <= PRIM_CNT_W0;
        end
        else if (rx_byte_valid)
        begin
            pos_r <= first_pos ? 2'h1 : pos_r + 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            asm_r <= '0;
        end
        else if (rx_byte_valid)
        begin
            if (first_pos)
            begin
                asm_r.byte0 <= rx_byte;
                asm_r.is_k <= {3'h0, rx_byte_is_k};
                asm_r.code_err <= rx_byte_err;
            end
            else
            begin
                unique case (pos_r)
                    2'h1: asm_r.byte1 <= rx_byte;
                    2'h2: asm_r.byte2 <= rx_byte;
                    default: asm_r.byte3 <= rx_byte;
                endcase
                asm_r.is_k[pos_r] <= rx_byte_is_k;
                asm_r.code_err <= asm_r.code_err | rx_byte_err;
            end
        end
    end

    // ----------------------------------------
    // Dword hand-over on the fourth byte
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dw_r <= '0;
            dw_stb_r <= 1'b0;
        end
        else
        begin
            dw_stb_r <= last_pos;
            if (last_pos)
            begin
                dw_r <= asm_r;
                dw_r.byte3 <= rx_byte;
                dw_r.is_k[3] <= rx_byte_is_k;
                dw_r.code_err <= asm_r.code_err | rx_byte_err;
            end
        end
    end

    // ----------------------------------------
    // Dword classification
    // ----------------------------------------
    logic dw_ok;
    logic dw_prim;

    assign dw_prim = (dw_r.is_k == 4'h1) &&
        ((dw_r.byte0 == K28_5_BYTE) || (dw_r.byte0 == K28_3_BYTE));
    assign dw_ok = !dw_r.code_err && (dw_prim || dw_r.is_k == 4'h0);

    // ----------------------------------------
    // Synchronisation state machine
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        if (los_r)
        begin
            state_nxt = ACQ_START;
        end
        else if (dw_stb_r)
        begin
            unique case (state_r)
                ACQ_START:
                    state_nxt = (dw_ok && dw_prim) ? ACQ_ONE : ACQ_START;
                ACQ_ONE:
                    state_nxt = !dw_ok ? ACQ_START : (dw_prim ? ACQ_TWO : ACQ_ONE);
                ACQ_TWO:
                    state_nxt = !dw_ok ? ACQ_START : (dw_prim ? SYNC_ACQ : ACQ_TWO);
                SYNC_ACQ:
                    state_nxt = dw_ok ? SYNC_ACQ : LOSE_ONE;
                LOSE_ONE:
                    state_nxt = dw_ok ? LOSE_ONE_V : LOSE_TWO;
                LOSE_ONE_V:
                    state_nxt = dw_ok ? SYNC_ACQ : LOSE_TWO;
                LOSE_TWO:
                    state_nxt = dw_ok ? LOSE_TWO_V : LOSE_THREE;
                LOSE_TWO_V:
                    state_nxt = dw_ok ? LOSE_ONE : LOSE_THREE;
                LOSE_THREE:
                    state_nxt = dw_ok ? LOSE_THREE_V : ACQ_START;
                LOSE_THREE_V:
                    state_nxt = dw_ok ? LOSE_TWO : ACQ_START;
                default:
                    state_nxt = ACQ_START;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ACQ_START;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic in_sync;
    logic in_sync_nxt;
    logic pass_dw;

    assign in_sync = !(state_r inside {ACQ_START, ACQ_ONE, ACQ_TWO});
    assign in_sync_nxt = !(state_nxt inside {ACQ_START, ACQ_ONE, ACQ_TWO});
    assign pass_dw = dw_stb_r && !los_r && (in_sync || state_nxt == SYNC_ACQ);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_valid <= 1'b0;
        end
        else
        begin
            sync_valid <= in_sync_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            conn_enable <= 1'b0;
        end
        else
        begin
            conn_enable <= in_sync_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_lost <= 1'b0;
        end
        else
        begin
            sync_lost <= in_sync && !in_sync_nxt;
        end
    end

    // ----------------------------------------
    // Dword and relay paths
    // ----------------------------------------
    // Downstream dword register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_dword <= '0;
            out_valid <= 1'b0;
            out_invalid <= 1'b0;
        end
        else
        begin
            out_dword <= dw_r;
            out_valid <= pass_dw;
            out_invalid <= pass_dw && in_sync && !dw_ok;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            relay_dword <= '0;
            relay_valid <= 1'b0;
        end
        else
        begin
            relay_valid <= pass_dw;
            if (!dw_ok)
            begin
                relay_dword <= sata_mode ? SATA_ERROR_PRIM : ERROR_PRIM;
            end
            else
            begin
                relay_dword <= {dw_r.byte3, dw_r.byte2, dw_r.byte1, dw_r.byte0};
            end
        end
    end

endmodule

//--- testbench/dword_sync_properties.sv
`timescale 1ns/1ps
module dword_sync_checker
    import dword_sync_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic loss_of_signal,
    input wire logic sata_mode,
    input wire logic sync_valid,
    input wire logic conn_enable,
    input wire dword_sync_pkg::rx_dword_t out_dword,
    input wire logic out_valid,
    input wire logic out_invalid,
    input wire logic [31:0] relay_dword,
    input wire logic relay_valid,
    input wire logic sync_lost
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence los_held;
        loss_of_signal [*6];
    endsequence
    conn_match_a: assert property (conn_enable == sync_valid)
        else $error("enable differs from sync");
    lost_cause_a: assert property (sync_lost |-> $past(sync_valid) && !sync_valid)
        else $error("loss pulse without drop");
    fall_reason_a: assert property ($fell(sync_valid) |-> sync_lost)
        else $error("sync dropped silently");
    data_withheld_a: assert property (out_valid |-> sync_valid || (sync_lost && out_invalid))
        else $error("dword passed outside sync");
    relay_timing_a: assert property (relay_valid == out_valid)
        else $error("relay strobe misplaced");
    error_subst_a: assert property (out_invalid |->
        relay_dword == ($past(sata_mode) ? SATA_ERROR_PRIM_DEFAULT : ERROR_PRIM_DEFAULT))
        else $error("invalid dword relayed");
    byte_order_a: assert property (relay_valid && !out_invalid |-> relay_dword ==
        {out_dword.byte3, out_dword.byte2, out_dword.byte1, out_dword.byte0})
        else $error("relay byte order wrong");
    los_drop_a: assert property (los_held |=> !sync_valid)
        else $error("sync kept under signal loss");
endmodule
bind dword_sync_machine dword_sync_checker chk (.core_clk, .reset_n, .loss_of_signal,
    .sata_mode, .sync_valid, .conn_enable, .out_dword, .out_valid, .out_invalid,
    .relay_dword, .relay_valid, .sync_lost);

//--- testbench/dword_tx_model.sv
`timescale 1ns/1ps
module dword_tx_model (
    input wire logic core_clk,
    output logic [7:0] rx_byte,
    output logic rx_byte_is_k,
    output logic rx_byte_err,
    output logic rx_byte_valid
);
    initial
    begin
        rx_byte = 8'h00;
        rx_byte_is_k = 1'b0;
        rx_byte_err = 1'b0;
        rx_byte_valid = 1'b0;
    end
    task automatic put(input logic [7:0] b, input logic k, input logic e);
        @(posedge core_clk);
        rx_byte <= b;
        rx_byte_is_k <= k;
        rx_byte_err <= e;
        rx_byte_valid <= 1'b1;
    endtask
    task automatic send(input logic [31:0] d, input logic [3:0] k, input logic e);
        for (int i = 0; i < 4; i++)
            put(d[8*i +: 8], k[i], e);
        @(posedge core_clk);
        rx_byte <= ~d[31:24];
        rx_byte_is_k <= 1'b0;
        rx_byte_valid <= 1'b0;
    endtask
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin bad_count++; \
    $display("BAD %s exp %0h got %0h", nm, ex, sn); end end
module testbench;
    import dword_sync_pkg::*;
    localparam logic [31:0] PRIM = {24'h332211, K28_5_BYTE};
    localparam logic [31:0] SPRIM = {24'h665544, K28_3_BYTE};
    localparam logic [31:0] DATA = 32'h44332211;
    logic core_clk = 0;
    logic reset_n = 0;
    logic loss_of_signal = 0;
    logic sata_mode = 0;
    logic [7:0] rx_byte;
    logic rx_byte_is_k, rx_byte_err, rx_byte_valid;
    logic sync_valid, conn_enable, out_valid, out_invalid, relay_valid, sync_lost;
    rx_dword_t out_dword, od;
    logic [31:0] relay_dword, rl;
    int bad_count = 0, compares = 0, lost_cnt = 0, ov_cnt = 0, cyc = 0, inv_cnt = 0;
    dword_tx_model tx (.core_clk, .rx_byte, .rx_byte_is_k, .rx_byte_err, .rx_byte_valid);
    dword_sync_machine DUT (.core_clk, .reset_n, .rx_byte, .rx_byte_is_k, .rx_byte_err,
        .rx_byte_valid, .loss_of_signal, .sata_mode, .sync_valid, .conn_enable, .out_dword,
        .out_valid, .out_invalid, .relay_dword, .relay_valid, .sync_lost);
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    task end_sim;
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (sync_lost === 1'b1) lost_cnt++;
        if (out_valid === 1'b1) ov_cnt++;
        if (out_invalid === 1'b1) inv_cnt++;
        if (out_valid === 1'b1) od = out_dword;
        if (relay_valid === 1'b1) rl = relay_dword;
        if (cyc == 5000)
        begin
            bad_count++;
            end_sim();
        end
    end
    task automatic dw(input logic [31:0] d, input logic [3:0] k, input logic e);
        tx.send(d, k, e);
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic g();
        dw(DATA, 4'h0, 1'b0);
    endtask
    task automatic b();
        dw(DATA, 4'h0, 1'b1);
    endtask
    task automatic t_acquire();
        int n = ov_cnt;
        tx.put(8'h55, 1'b0, 1'b0);
        dw(PRIM, 4'h1, 1'b0);
        dw(PRIM, 4'h1, 1'b0);
        `CHK("sync_early", 1'b0, sync_valid)
        `CHK("withheld", n, ov_cnt)
        dw(PRIM, 4'h1, 1'b0);
        `CHK("sync", 1'b1, sync_valid)
        `CHK("conn", 1'b1, conn_enable)
        `CHK("aligned", K28_5_BYTE, od.byte0)
        `CHK("k_flags", 4'h1, od.is_k)
    endtask
    task automatic t_relay();
        int m = inv_cnt;
        @(posedge core_clk) sata_mode <= 1'b1;
        b();
        `CHK("sata_err", SATA_ERROR_PRIM_DEFAULT, rl)
        @(posedge core_clk) sata_mode <= 1'b0;
        b();
        `CHK("err", ERROR_PRIM_DEFAULT, rl)
        g(); g(); g();
        `CHK("relay", DATA, rl)
        `CHK("flagged", m + 2, inv_cnt)
        `CHK("first_byte", 8'h11, od.byte0)
        g();
        `CHK("recovered", 1'b1, sync_valid)
    endtask
    task automatic t_ladder();
        int n = lost_cnt;
        b(); b(); dw(DATA, 4'h2, 1'b0);
        g(); dw(SPRIM, 4'h1, 1'b0); g(); g(); g(); g();
        b(); b(); b();
        `CHK("held", 1'b1, sync_valid)
        `CHK("no_loss", n, lost_cnt)
        b();
        `CHK("lost", n + 1, lost_cnt)
        `CHK("dropped", 1'b0, sync_valid)
    endtask
    task automatic t_alt();
        int n = lost_cnt;
        b(); g(); b(); g(); b(); g();
        `CHK("alt_held", n, lost_cnt)
        b();
        `CHK("alt_lost", n + 1, lost_cnt)
    endtask
    task automatic t_los();
        int n = lost_cnt;
        b();
        @(posedge core_clk) loss_of_signal <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        `CHK("los_sync", 1'b0, sync_valid)
        `CHK("los_lost", n + 1, lost_cnt)
        @(posedge core_clk) loss_of_signal <= 1'b0;
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_acquire();
        t_relay();
        t_ladder();
        t_acquire();
        t_alt();
        t_acquire();
        t_los();
        end_sim();
    end
endmodule
